// ---- logic/nvc_config_ctrl.sv ----
// What this block does
// RQ1: No program or erase cycle starts while the ten-bit divider is zero.
// RQ2: Reset loads config bits 7:4 from shadow; bit3=1, wait-stop=1, lock and scratch=0.
// RQ3: Config bit 3 always reads one and ignores writes.
// RQ4: Software should leave shadow test bits 5 and 4 unprogrammed.
// RQ5: Debug-lockout-disable is writable only in special mode.
// RQ6: Shadow-disable low maps shadow word over array bytes 0FC0 and 0FC1.
// RQ7: Shadow-disable loads from shadow, always readable, written only in special mode.
// RQ8: Reset copies shadow high 1:0 to divider high and shadow low to divider low.
// RQ9: Bulk program or erase happens only while the shadow word is enabled.
// RQ10: Software should leave shadow bit 6 unprogrammed for full array visibility.
// RQ11: Wait-stop high gates the module clock during wait mode.
// RQ12: Software keeps wait-stop clear if wait vectors live in the array.
// RQ13: Protection-lock high blocks writes to block-protect and bulk-protect bits.
// RQ14: Normal mode allows one lock write after reset; special mode any number.
// RQ15: High-voltage enable sets only when latch already set.
// RQ16: High-voltage enable freezes bulk-protect, auto, byte, row, erase and latch.
// RQ17: With auto set, high-voltage enable clears itself when the cycle ends.
// RQ18: Erase size follows byte and row: array, row, or latched location.
`timescale 1ns/100ps
`default_nettype none
module nvc_config_ctrl #(
   parameter int CYCLE_TICKS = 286
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic special_mode_n,
   input wire logic wait_mode,
   input wire logic [15:0] shadow_word,
   input wire logic selftime_tick,
   input wire logic [11:0] array_addr,
   output logic shadow_select,
   output logic module_clock_enable,
   output logic [7:0] nvm_module_config,
   output logic [7:0] nvm_program_control,
   output logic [9:0] selftime_divider,
   output logic high_voltage_on,
   output logic bulk_allowed,
   output nvc_pkg::nvc_erase_size_t erase_size,
   output logic block_protect_write_en
);
   logic special_sync2;
   logic wait_sync2;
   logic loaded;
   logic lock_written;
   logic div_written;
   logic [15:0] tick_count;
   logic cycle_done;
   logic wr_cycle;
   logic [7:0] wb;
   logic is_special;
   logic [7:0] pc;
   logic [7:0] next_pc;
   logic [7:0] next_mc;

   assign wr_cycle = psel && penable && pwrite && pready;
   assign wb = pwdata[7:0];
   assign is_special = !special_sync2;
   assign pc = nvm_program_control;

   // Mode pins come from another domain; two stages before any use.
   // Special mode resets as normal so no protected bit opens during reset.
   nvc_sync2 #(
      .RESET_VALUE(1'b1)
   ) u_special_sync (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(special_mode_n),
      .sync_out(special_sync2)
   );

   nvc_sync2 #(
      .RESET_VALUE(1'b0)
   ) u_wait_sync (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(wait_mode),
      .sync_out(wait_sync2)
   );

   // APB answers in the access cycle, so there are never wait states.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   // Every filtered write is dropped silently; the bus never reports an error.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= 1'b0;
      end
   end

   // Read data is captured in the setup cycle; unmapped offsets read zero.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               nvc_pkg::NVC_OFF_MODULE_CONFIG: prdata <= {24'h000000, nvm_module_config};
               nvc_pkg::NVC_OFF_PROGRAM_CONTROL: prdata <= {24'h000000, nvm_program_control};
               nvc_pkg::NVC_OFF_DIVIDER_HIGH: prdata <= {30'h0000_0000, selftime_divider[9:8]};
               nvc_pkg::NVC_OFF_DIVIDER_LOW: prdata <= {24'h000000, selftime_divider[7:0]};
               nvc_pkg::NVC_OFF_STATUS: prdata <= {29'h0000_0000, loaded, lock_written,
                                                   div_written};
               nvc_pkg::NVC_OFF_CYCLE: prdata <= {16'h0000, tick_count};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // The shadow word is a level from the array; it is captured once after release.
   always_comb begin
      next_mc = nvm_module_config;
      if (wr_cycle && paddr == nvc_pkg::NVC_OFF_MODULE_CONFIG) begin
         if (is_special) begin
            next_mc[nvc_pkg::NVC_MC_DEBUG_LOCKOUT_DISABLE] =
               wb[nvc_pkg::NVC_MC_DEBUG_LOCKOUT_DISABLE]; // RQ5
            next_mc[nvc_pkg::NVC_MC_SHADOW_DISABLE] = wb[nvc_pkg::NVC_MC_SHADOW_DISABLE]; // RQ7
         end
         next_mc[nvc_pkg::NVC_MC_WAIT_CLOCK_STOP] = wb[nvc_pkg::NVC_MC_WAIT_CLOCK_STOP]; // RQ11
         next_mc[nvc_pkg::NVC_MC_SCRATCH_BIT] = wb[nvc_pkg::NVC_MC_SCRATCH_BIT];
         if (is_special || !lock_written) begin
            next_mc[nvc_pkg::NVC_MC_PROTECTION_LOCK] = wb[nvc_pkg::NVC_MC_PROTECTION_LOCK]; // RQ14
         end
      end
      next_mc[nvc_pkg::NVC_MC_CONST_ONE] = 1'b1; // RQ3
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nvm_module_config <= {4'h0, nvc_pkg::NVC_MC_LOW_RESET};
         loaded <= 1'b0;
         lock_written <= 1'b0;
      end else if (!loaded) begin
         nvm_module_config <= {shadow_word[15:12], nvc_pkg::NVC_MC_LOW_RESET}; // RQ2
         loaded <= 1'b1;
      end else begin
         nvm_module_config <= next_mc;
         if (wr_cycle && paddr == nvc_pkg::NVC_OFF_MODULE_CONFIG) begin
            lock_written <= 1'b1; // RQ14
         end
      end
   end

   // Divider: loaded from shadow, writable while latch is clear, once in normal mode.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         selftime_divider <= 10'h000;
         div_written <= 1'b0;
      end else if (!loaded) begin
         selftime_divider <= {shadow_word[9:8], shadow_word[7:0]}; // RQ8
      end else if (wr_cycle && !pc[nvc_pkg::NVC_PC_LATCH_SETUP] &&
                   (is_special || !div_written)) begin
         if (paddr == nvc_pkg::NVC_OFF_DIVIDER_HIGH) begin
            selftime_divider[9:8] <= wb[1:0];
            div_written <= 1'b1;
         end else if (paddr == nvc_pkg::NVC_OFF_DIVIDER_LOW) begin
            selftime_divider[7:0] <= wb;
            div_written <= 1'b1;
         end
      end
   end

   // Program control write filtering.
   always_comb begin
      next_pc = pc;
      if (wr_cycle && paddr == nvc_pkg::NVC_OFF_PROGRAM_CONTROL) begin
         if (!pc[nvc_pkg::NVC_PC_HIGH_VOLTAGE_ENABLE]) begin
            next_pc[nvc_pkg::NVC_PC_AUTO] = wb[nvc_pkg::NVC_PC_AUTO];
            next_pc[nvc_pkg::NVC_PC_BYTE] = wb[nvc_pkg::NVC_PC_BYTE];
            next_pc[nvc_pkg::NVC_PC_ROW] = wb[nvc_pkg::NVC_PC_ROW];
            next_pc[nvc_pkg::NVC_PC_ERASE] = wb[nvc_pkg::NVC_PC_ERASE];
            if (!nvm_module_config[nvc_pkg::NVC_MC_PROTECTION_LOCK]) begin
               next_pc[nvc_pkg::NVC_PC_BULK_PROTECT] = wb[nvc_pkg::NVC_PC_BULK_PROTECT]; // RQ13
            end
            if (selftime_divider != 10'h000) begin
               next_pc[nvc_pkg::NVC_PC_LATCH_SETUP] = wb[nvc_pkg::NVC_PC_LATCH_SETUP];
            end
         end // RQ16
         if (pc[nvc_pkg::NVC_PC_LATCH_SETUP] && selftime_divider != 10'h000) begin // RQ1
            next_pc[nvc_pkg::NVC_PC_HIGH_VOLTAGE_ENABLE] =
               wb[nvc_pkg::NVC_PC_HIGH_VOLTAGE_ENABLE]; // RQ15
         end else begin
            next_pc[nvc_pkg::NVC_PC_HIGH_VOLTAGE_ENABLE] = 1'b0; // RQ15
         end
      end
      // A finishing auto cycle wins over a concurrent software write.
      if (cycle_done && pc[nvc_pkg::NVC_PC_AUTO]) begin
         next_pc[nvc_pkg::NVC_PC_HIGH_VOLTAGE_ENABLE] = 1'b0; // RQ17
      end
      next_pc = next_pc & nvc_pkg::NVC_PC_WRITABLE;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nvm_program_control <= nvc_pkg::NVC_PC_RESET;
      end else begin
         nvm_program_control <= next_pc;
      end
   end

   // Self-timed cycle length, counted on the divider's tick enable.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_count <= 16'h0000;
         cycle_done <= 1'b0;
      end else begin
         cycle_done <= 1'b0;
         if (!pc[nvc_pkg::NVC_PC_HIGH_VOLTAGE_ENABLE]) begin
            tick_count <= 16'h0000;
         end else if (selftime_tick && !cycle_done) begin
            if (tick_count == 16'(CYCLE_TICKS - 1)) begin
               cycle_done <= 1'b1;
               tick_count <= 16'h0000;
            end else begin
               tick_count <= tick_count + 16'h0001;
            end
         end
      end
   end

   // Derived outputs, each registered, so they trail their register by one edge.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shadow_select <= 1'b0;
      end else begin
         shadow_select <= !nvm_module_config[nvc_pkg::NVC_MC_SHADOW_DISABLE] &&
                          (array_addr == nvc_pkg::NVC_SHADOW_ADDR_HIGH ||
                           array_addr == nvc_pkg::NVC_SHADOW_ADDR_LOW); // RQ6
      end
   end

   // The clock runs out of reset so that the shadow load can complete.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         module_clock_enable <= 1'b1;
      end else begin
         module_clock_enable <= !(wait_sync2 &&
                                  nvm_module_config[nvc_pkg::NVC_MC_WAIT_CLOCK_STOP]); // RQ11
      end
   end

   // A zero divider also blocks the pump here, as a second line of defence.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         high_voltage_on <= 1'b0;
      end else begin
         high_voltage_on <= pc[nvc_pkg::NVC_PC_HIGH_VOLTAGE_ENABLE] &&
                            selftime_divider != 10'h000; // RQ1
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bulk_allowed <= 1'b0;
      end else begin
         bulk_allowed <= !nvm_module_config[nvc_pkg::NVC_MC_SHADOW_DISABLE] &&
                         !pc[nvc_pkg::NVC_PC_BULK_PROTECT]; // RQ9
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         block_protect_write_en <= 1'b1;
      end else begin
         block_protect_write_en <= !nvm_module_config[nvc_pkg::NVC_MC_PROTECTION_LOCK]; // RQ13
      end
   end

   // Byte wins over row, so a location erase never widens to a row.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         erase_size <= nvc_pkg::NVC_ERASE_NONE;
      end else begin
         if (!pc[nvc_pkg::NVC_PC_ERASE]) begin
            erase_size <= nvc_pkg::NVC_ERASE_NONE;
         end else if (pc[nvc_pkg::NVC_PC_BYTE]) begin
            erase_size <= nvc_pkg::NVC_ERASE_LOCATION; // RQ18
         end else if (pc[nvc_pkg::NVC_PC_ROW]) begin
            erase_size <= nvc_pkg::NVC_ERASE_ROW; // RQ18
         end else begin
            erase_size <= nvc_pkg::NVC_ERASE_ARRAY; // RQ18
         end
      end
   end
endmodule : nvc_config_ctrl

// Two-stage synchroniser; only the second stage may be read by logic.
module nvc_sync2 #(
   parameter logic RESET_VALUE = 1'b0
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic async_in,
   output logic sync_out
);
   logic stage1;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : nvc_sync2
`default_nettype wire

// ---- shared/nvc_pkg.sv ----
`default_nettype none
package nvc_pkg;
   localparam logic [7:0] NVC_OFF_MODULE_CONFIG = 8'hF0;
   localparam logic [7:0] NVC_OFF_PROGRAM_CONTROL = 8'hF3;
   localparam logic [7:0] NVC_OFF_DIVIDER_HIGH = 8'hEE;
   localparam logic [7:0] NVC_OFF_DIVIDER_LOW = 8'hEF;
   localparam logic [7:0] NVC_OFF_STATUS = 8'hF8;
   localparam logic [7:0] NVC_OFF_CYCLE = 8'hFC;
   // Module configuration bit positions.
   localparam int NVC_MC_DEBUG_LOCKOUT_DISABLE = 7;
   localparam int NVC_MC_SHADOW_DISABLE = 6;
   localparam int NVC_MC_CONST_ONE = 3;
   localparam int NVC_MC_WAIT_CLOCK_STOP = 2;
   localparam int NVC_MC_PROTECTION_LOCK = 1;
   localparam int NVC_MC_SCRATCH_BIT = 0;
   // Program control bit positions.
   localparam int NVC_PC_BULK_PROTECT = 7;
   localparam int NVC_PC_AUTO = 5;
   localparam int NVC_PC_BYTE = 4;
   localparam int NVC_PC_ROW = 3;
   localparam int NVC_PC_ERASE = 2;
   localparam int NVC_PC_LATCH_SETUP = 1;
   localparam int NVC_PC_HIGH_VOLTAGE_ENABLE = 0;
   localparam logic [3:0] NVC_MC_LOW_RESET = 4'h C;
   localparam logic [7:0] NVC_PC_RESET = 8'h80;
   localparam logic [7:0] NVC_PC_WRITABLE = 8'hBF;
   localparam logic [11:0] NVC_SHADOW_ADDR_HIGH = 12'hFC0;
   localparam logic [11:0] NVC_SHADOW_ADDR_LOW = 12'hFC1;
   typedef enum logic [1:0] {
      NVC_ERASE_ARRAY,
      NVC_ERASE_ROW,
      NVC_ERASE_LOCATION,
      NVC_ERASE_NONE
   } nvc_erase_size_t;
   typedef struct packed {
      logic [11:0] addr;
      logic wr;
      logic [7:0] wdata;
   } nvc_array_req_t;
endpackage : nvc_pkg
`default_nettype wire

// ---- bench/nvc_config_ctrl_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module nvc_config_ctrl_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wait_mode,
   input wire logic [11:0] array_addr,
   input wire logic shadow_select,
   input wire logic module_clock_enable,
   input wire logic [7:0] nvm_module_config,
   input wire logic [7:0] nvm_program_control,
   input wire logic [9:0] selftime_divider,
   input wire logic bulk_allowed,
   input wire nvc_pkg::nvc_erase_size_t erase_size
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   const_one_a: assert property (nvm_module_config[3])
      else $error("config bit 3 not one");
   shadow_sel_a: assert property (array_addr == 12'hFC1 && !nvm_module_config[6] |=> shadow_select)
      else $error("shadow word not selected");
   hv_needs_latch_a: assert property ($rose(nvm_program_control[0]) |->
      $past(nvm_program_control[1]) && $past(selftime_divider) != 10'h000)
      else $error("enable set without latch or divider");
   freeze_bits_a: assert property (nvm_program_control[0] |=> $stable(nvm_program_control[7:1]))
      else $error("control bits changed while enabled");
   wait_gate_a: assert property ((wait_mode && nvm_module_config[2]) [*4] |-> !module_clock_enable)
      else $error("clock not stopped in wait");
   lock_bulk_a: assert property (nvm_module_config[1] |=> $stable(nvm_program_control[7]))
      else $error("bulk protect changed while locked");
   bulk_shadow_a: assert property (nvm_module_config[6] |=> !bulk_allowed)
      else $error("bulk allowed with shadow off");
   erase_map_a: assert property (nvm_program_control[2] |=> erase_size ==
      ($past(nvm_program_control[4]) ? nvc_pkg::NVC_ERASE_LOCATION :
      ($past(nvm_program_control[3]) ? nvc_pkg::NVC_ERASE_ROW : nvc_pkg::NVC_ERASE_ARRAY)))
      else $error("erase size mismatch");
endmodule : nvc_config_ctrl_checker
bind nvc_config_ctrl nvc_config_ctrl_checker u_chk (.clk, .rst_b, .wait_mode, .array_addr,
   .shadow_select, .module_clock_enable, .nvm_module_config, .nvm_program_control,
   .selftime_divider, .bulk_allowed, .erase_size);
`default_nettype wire

// ---- bench/nvc_config_ctrl_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module nvc_config_ctrl_tb;
   localparam logic [7:0] MC = nvc_pkg::NVC_OFF_MODULE_CONFIG;
   localparam logic [7:0] PC = nvc_pkg::NVC_OFF_PROGRAM_CONTROL;
   logic clk, rst_b, psel, penable, pwrite, special_mode_n, wait_mode, selftime_tick, pready;
   logic shadow_select, module_clock_enable, high_voltage_on, bulk_allowed;
   logic pslverr, block_protect_write_en;
   logic [7:0] paddr, cfg, pc;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] shadow_word;
   logic [11:0] array_addr;
   logic [9:0] div;
   nvc_pkg::nvc_erase_size_t erase_size;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   nvc_config_ctrl #(.CYCLE_TICKS(4)) DUT (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .special_mode_n, .wait_mode, .shadow_word,
      .selftime_tick, .array_addr, .shadow_select, .module_clock_enable,
      .nvm_module_config(cfg), .nvm_program_control(pc), .selftime_divider(div),
      .high_voltage_on, .bulk_allowed, .erase_size, .block_protect_write_en);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic stop_test();
      if (err_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count = err_count + 1;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Holds the request until pready is sampled high; read data is taken at that edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      chk({31'h0, pready}, 32'h1);
      chk({31'h0, pslverr}, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(rd, {24'h000000, e});
   endtask : rdc
   // Derived outputs settle one edge after the register they follow.
   task automatic es(input nvc_pkg::nvc_erase_size_t e);
      repeat (2) @(posedge clk);
      chk({30'h0, erase_size}, {30'h0, e});
   endtask : es
   task automatic t_reset();
      rdc(MC, 8'h7C);
      rdc(nvc_pkg::NVC_OFF_DIVIDER_HIGH, 8'h02);
      rdc(nvc_pkg::NVC_OFF_DIVIDER_LOW, 8'h03);
      rdc(8'h10, 8'h00);
      chk({31'h0, shadow_select}, 32'h0);
   endtask : t_reset
   task automatic t_normal();
      apb(1'b1, MC, 8'hCF);
      rdc(MC, 8'h7F);
      wait_mode <= 1'b1;
      repeat (5) @(posedge clk);
      chk({31'h0, module_clock_enable}, 32'h0);
      apb(1'b1, MC, 8'h88);
      rdc(MC, 8'h7A);
      repeat (4) @(posedge clk);
      chk({31'h0, module_clock_enable}, 32'h1);
      wait_mode <= 1'b0;
      apb(1'b1, PC, 8'h00);
      rdc(PC, 8'h80);
      chk({31'h0, block_protect_write_en}, 32'h0);
   endtask : t_normal
   task automatic t_special();
      special_mode_n <= 1'b0;
      repeat (4) @(posedge clk);
      apb(1'b1, MC, 8'h40);
      rdc(MC, 8'h78);
      chk({31'h0, shadow_select}, 32'h0);
      chk({31'h0, bulk_allowed}, 32'h0);
      apb(1'b1, MC, 8'h02);
      apb(1'b1, MC, 8'h00);
      rdc(MC, 8'h38);
      chk({31'h0, shadow_select}, 32'h1);
      chk({31'h0, block_protect_write_en}, 32'h1);
   endtask : t_special
   task automatic t_program();
      apb(1'b1, PC, 8'h03);
      rdc(PC, 8'h02);
      apb(1'b1, PC, 8'h26);
      rdc(PC, 8'h26);
      es(nvc_pkg::NVC_ERASE_ARRAY);
      chk({31'h0, bulk_allowed}, 32'h1);
      apb(1'b1, PC, 8'h2E);
      es(nvc_pkg::NVC_ERASE_ROW);
      apb(1'b1, PC, 8'h36);
      es(nvc_pkg::NVC_ERASE_LOCATION);
      apb(1'b1, PC, 8'h37);
      apb(1'b1, PC, 8'h21);
      rdc(PC, 8'h37);
      chk({31'h0, high_voltage_on}, 32'h1);
      repeat (4) begin
         @(posedge clk);
         selftime_tick <= 1'b1;
         @(posedge clk);
         selftime_tick <= 1'b0;
      end
      repeat (3) @(posedge clk);
      rdc(PC, 8'h36);
   endtask : t_program
   task automatic t_div_zero();
      apb(1'b1, PC, 8'h00);
      apb(1'b1, nvc_pkg::NVC_OFF_DIVIDER_HIGH, 8'h00);
      apb(1'b1, nvc_pkg::NVC_OFF_DIVIDER_LOW, 8'h00);
      apb(1'b1, PC, 8'h02);
      apb(1'b1, PC, 8'h03);
      rdc(PC, 8'h00);
   endtask : t_div_zero
   initial begin
      {rst_b, psel, penable, pwrite, wait_mode, selftime_tick} = '0;
      special_mode_n = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      shadow_word = 16'h7E03;
      array_addr = 12'hFC1;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset();
      t_normal();
      t_special();
      t_program();
      t_div_zero();
      stop_test();
   end
endmodule : nvc_config_ctrl_tb
`default_nettype wire
